// >>> verilog/usb_ep_defines.svh
// Offsets, field positions, mode codes and counts of the endpoint block.
// Assumes inclusion by bare name from the main module.
`ifndef USB_EP_DEFINES_SVH
`define USB_EP_DEFINES_SVH

// Data endpoint mode registers in processor I/O space
`define DATA_EP1_MODE_ADDR 8'h45
`define DATA_EP2_MODE_ADDR 8'h46
// Endpoint buffers, eight bytes each
`define CTRL_BUF_BASE 8'h50
`define DATA1_BUF_BASE 8'h58
`define DATA2_BUF_BASE 8'h60
`define BUF_LAST_ADDR 8'h67
`define BUF_BYTES 24
// Mode register fields and reset
`define MODE_STALL_BIT 7
`define MODE_NAKIE_BIT 5
`define MODE_ACKED_BIT 4
`define MODE_REG_RESET 8'h00
// Endpoint mode encodings
`define MODE_DISABLED 4'h0
`define MODE_NAK_IN_OUT 4'h1
`define MODE_STATUS_OUT 4'h2
`define MODE_STALL_IN_OUT 4'h3
`define MODE_STATUS_IN 4'h6
`define MODE_ACK_OUT_STATUS_IN 4'hb
`define MODE_ACK_IN_STATUS_OUT 4'hf
`define MODE_NAK_OUT 4'h8
`define MODE_ACK_OUT 4'h9
`define MODE_NAK_IN 4'hc
`define MODE_ACK_IN 4'hd
// Received count includes two CRC bytes
`define RX_COUNT_MAX 4'ha
`define RX_COUNT_EMPTY 4'h2
`define READ_UNMAPPED 8'h00

`endif

// >>> verilog/usb_ep_pkg.sv
// Types shared by the endpoint mode block and its output buffer.
// Assumes the defines header sits beside it.
package usb_ep_pkg;

  typedef enum logic [1:0] {
    TK_SETUP = 2'h0,
    TK_IN = 2'h1,
    TK_OUT = 2'h2
  } tok_kind_t;

  // One decoded token, with the data packet summary for SETUP and OUT
  typedef struct packed {
    tok_kind_t kind;
    logic [1:0] ep;
    logic [3:0] count;
    logic data_ok;
    logic toggle;
  } token_t;

  typedef struct packed {
    logic [1:0] ep;
    logic [2:0] index;
    logic [7:0] data;
  } rx_byte_t;

  typedef enum logic [2:0] {
    R_NONE = 3'h0,
    R_ACK = 3'h1,
    R_NAK = 3'h2,
    R_STALL = 3'h3,
    R_TX = 3'h4
  } resp_t;

  typedef struct packed {
    logic stall;
    logic rsvd;
    logic nak_ie;
    logic acked;
    logic [3:0] mode;
  } ep_mode_t;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } tx_beat_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } tx_state_t;

endpackage

// >>> verilog/tx_skid_buffer.sv
// Two-entry buffer between the IN byte reader and the serial engine.
// Assumes a single clock; the head entry drives the outputs directly.
`timescale 1ns/1ns
module tx_skid_buffer (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic in_valid_in,
  input wire usb_ep_pkg::tx_beat_t in_beat_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output usb_ep_pkg::tx_beat_t out_beat_out,
  input wire logic out_ready_in
);
  import usb_ep_pkg::*;

  logic head_v_q;
  logic spare_v_q;
  tx_beat_t spare_q;
  wire push = in_valid_in && !spare_v_q;
  wire pop = head_v_q && out_ready_in;

  assign in_ready_out = !spare_v_q;

  // Spare entry catches a word while the drain side stalls
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      head_v_q <= 1'b0;
      spare_v_q <= 1'b0;
      out_beat_out <= '0;
      spare_q <= '0;
    end else if (push && pop) begin
      out_beat_out <= spare_v_q ? spare_q : in_beat_in;
      spare_q <= in_beat_in;
    end else if (push) begin
      head_v_q <= 1'b1;
      spare_v_q <= head_v_q;
      if (head_v_q) spare_q <= in_beat_in;
      else out_beat_out <= in_beat_in;
    end else if (pop) begin
      head_v_q <= spare_v_q;
      spare_v_q <= 1'b0;
      out_beat_out <= spare_q;
    end
  end

  assign out_valid_out = head_v_q;
endmodule // tx_skid_buffer

// >>> verilog/usb_endpoint_mode_control.sv
// Endpoint mode control: token handshakes, data endpoint mode registers
// and the three endpoint buffers in processor I/O space.
// Assumes a serial engine front end delivering decoded tokens, received
// data bytes and the host's IN acknowledge, all on clk_in.
// Functional notes
// (RQ1) Stall bit stalls in ACK-IN/ACK-OUT modes
// (RQ2) Firmware clears stall in other modes
// (RQ3) NAK raises interrupt only when enabled
// (RQ4) ACK sets acked flag; writes clear it
// (RQ5) Engine mode write beats firmware write
// (RQ6) Firmware reads back and rewrites mode
// (RQ7) Three eight-byte buffers at 0x50/58/60
// (RQ8) Buffers only in I/O space, unreset
// (RQ9) Mode 0000 ignores every token
// (RQ10) Mode 0001: accept SETUP, NAK IN/OUT
// (RQ11) Mode 0010: SETUP, STALL IN, check OUT
// (RQ12) Mode 0011: SETUP, STALL IN and OUT
// (RQ13) Mode 0110: SETUP, STALL OUT, empty IN
// (RQ14) Mode 1011: SETUP, ACK OUT, empty IN
// (RQ15) Mode 1111: SETUP, send count, check OUT
// (RQ16) Mode 1000: NAK OUT, ignore others
// (RQ17) Mode 1001: ACK OUT, then becomes 1000
// (RQ18) Mode 1001 stalled: STALL OUT
// (RQ19) Mode 1100: NAK IN, ignore others
// (RQ20) Mode 1101: send count, then 1100
// (RQ21) Mode 1101 stalled: STALL IN
// (RQ22) Reserved modes ignore all tokens
// (RQ23) Check acks only empty DATA1 OUT
// (RQ24) IN sends exactly the byte count
`timescale 1ns/1ns
`include "usb_ep_defines.svh"
module usb_endpoint_mode_control (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  output logic [7:0] io_rdata_out,
  input wire logic [3:0] ctrl_mode_in,
  input wire logic [2:0][3:0] tx_count_in,
  input wire logic tok_valid_in,
  input wire usb_ep_pkg::token_t tok_in,
  input wire logic rx_valid_in,
  input wire usb_ep_pkg::rx_byte_t rx_in,
  input wire logic host_ack_in,
  output logic resp_valid_out,
  output usb_ep_pkg::resp_t resp_out,
  output logic [3:0] resp_len_out,
  output logic [2:0] ep_irq_out,
  output logic tx_valid_out,
  output usb_ep_pkg::tx_beat_t tx_beat_out,
  input wire logic tx_ready_in
);
  import usb_ep_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Handshake decision

  // Response for one token given the endpoint's mode
  function automatic resp_t decide(input tok_kind_t kind,
                                   input logic ctrl,
                                   input logic [3:0] mode,
                                   input logic stall,
                                   input logic pkt_ok,
                                   input logic [3:0] count,
                                   input logic toggle);
    resp_t r;
    logic check;
    r = R_NONE;
    check = (count == `RX_COUNT_EMPTY) && toggle; // [RQ23]
    if (ctrl) begin
      case (mode)
        `MODE_NAK_IN_OUT, `MODE_STATUS_OUT, `MODE_STALL_IN_OUT,
        `MODE_STATUS_IN, `MODE_ACK_OUT_STATUS_IN,
        `MODE_ACK_IN_STATUS_OUT: begin
          if (kind == TK_SETUP) r = pkt_ok ? R_ACK : R_NONE;
          else if (kind == TK_IN) begin
            case (mode)
              `MODE_NAK_IN_OUT: r = R_NAK; // [RQ10]
              `MODE_STATUS_OUT, `MODE_STALL_IN_OUT: r = R_STALL; // [RQ11] [RQ12]
              default: r = R_TX; // [RQ13] [RQ14] [RQ15]
            endcase
          end else if (kind == TK_OUT && pkt_ok) begin
            case (mode)
              `MODE_NAK_IN_OUT: r = R_NAK; // [RQ10]
              `MODE_ACK_OUT_STATUS_IN: r = R_ACK; // [RQ14]
              `MODE_STATUS_OUT, `MODE_ACK_IN_STATUS_OUT:
                r = check ? R_ACK : R_STALL; // [RQ11] [RQ15] [RQ23]
              default: r = R_STALL; // [RQ12] [RQ13]
            endcase
          end
        end
        default: r = R_NONE; // Disabled and reserved [RQ9] [RQ22]
      endcase
    end else begin
      case (mode)
        `MODE_NAK_OUT:
          if (kind == TK_OUT && pkt_ok) r = R_NAK; // [RQ16]
        `MODE_ACK_OUT:
          if (kind == TK_OUT && pkt_ok)
            r = stall ? R_STALL : R_ACK; // [RQ1] [RQ17] [RQ18]
        `MODE_NAK_IN:
          if (kind == TK_IN) r = R_NAK; // [RQ19]
        `MODE_ACK_IN:
          if (kind == TK_IN)
            r = stall ? R_STALL : R_TX; // [RQ1] [RQ20] [RQ21]
        default: r = R_NONE; // [RQ9] [RQ22]
      endcase
    end
    return r;
  endfunction

  ep_mode_t [1:0] mode_q;
  ep_mode_t [1:0] mode_d;
  // Only endpoint 2 selects the second register; 1 and 3 the first
  wire tok_ctrl = (tok_in.ep == 2'h0);
  wire tok_sel = (tok_in.ep == 2'h2);
  wire ep_mode_t tok_reg = mode_q[tok_sel];
  wire [3:0] tok_mode = tok_ctrl ? ctrl_mode_in : tok_reg.mode;
  wire pkt_ok = tok_in.data_ok && (tok_in.count <= `RX_COUNT_MAX);
  wire resp_t decision = decide(tok_in.kind, tok_ctrl, tok_mode,
    tok_reg.stall, pkt_ok, tok_in.count, tok_in.toggle);
  // Status-IN control modes 0110 and 1011 always send an empty packet
  wire tx_empty = tok_ctrl && (tok_mode == `MODE_STATUS_IN ||
    tok_mode == `MODE_ACK_OUT_STATUS_IN);
  wire [3:0] tx_len = tx_empty ? 4'h0 : tx_count_in[tok_in.ep]; // [RQ24]
  wire tok_fire = tok_valid_in && (tok_in.ep != 2'h3);
  wire tok_nak_irq = !tok_ctrl && tok_reg.nak_ie;

  ////////////////////////////////////////////////////////////////////////
  // Pending IN, awaiting the host's acknowledge

  logic pend_q;
  logic [1:0] pend_ep_q;

  // Any new token to endpoints 0 to 2 abandons an IN the host never acknowledged
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pend_q <= 1'b0;
      pend_ep_q <= 2'h0;
    end else if (tok_fire) begin
      pend_q <= (decision == R_TX);
      pend_ep_q <= tok_in.ep;
    end else if (host_ack_in) begin
      pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data endpoint mode registers

  logic [1:0] out_ack;
  logic [1:0] in_ack;
  logic [1:0] eng_wr;
  logic [1:0] fw_wr;
  wire eng_upd = |eng_wr;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_mode
      wire [7:0] reg_addr = (gi == 0) ? `DATA_EP1_MODE_ADDR :
        `DATA_EP2_MODE_ADDR;
      wire [1:0] ep_num = 2'(gi + 1);
      assign out_ack[gi] = tok_fire && tok_in.kind == TK_OUT &&
        tok_in.ep == ep_num && decision == R_ACK;
      assign in_ack[gi] = host_ack_in && pend_q && pend_ep_q == ep_num &&
        mode_q[gi].mode == `MODE_ACK_IN;
      assign eng_wr[gi] = out_ack[gi] || in_ack[gi];
      // One shared update strobe: any engine write drops firmware's
      assign fw_wr[gi] = io_wr_in && io_addr_in == reg_addr &&
        !eng_upd; // [RQ5]
      // Engine sets acked and steps the mode; firmware write clears acked
      assign mode_d[gi] = eng_wr[gi] ?
        {mode_q[gi][7:5], 1'b1,
         out_ack[gi] ? `MODE_NAK_OUT : `MODE_NAK_IN} : // [RQ4] [RQ17] [RQ20]
        fw_wr[gi] ? {io_wdata_in[7:5], 1'b0, io_wdata_in[3:0]} : // [RQ4]
        mode_q[gi];
    end
  endgenerate

  // Both mode registers
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) mode_q <= {`MODE_REG_RESET, `MODE_REG_RESET};
    else mode_q <= mode_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Endpoint buffers, no reset so contents start undefined

  logic [7:0] buf_mem [0:`BUF_BYTES-1];
  wire [7:0] io_off = io_addr_in - `CTRL_BUF_BASE;
  wire io_in_buf = io_addr_in >= `CTRL_BUF_BASE &&
    io_addr_in <= `BUF_LAST_ADDR; // [RQ7] [RQ8]
  wire fw_buf_wr = io_wr_in && io_in_buf;
  wire rx_wr = rx_valid_in && rx_in.ep != 2'h3;

  // Firmware and engine writes; the engine lands second and wins a tie
  always_ff @(posedge clk_in) begin
    if (fw_buf_wr) buf_mem[io_off[4:0]] <= io_wdata_in; // [RQ8]
    if (rx_wr) buf_mem[{rx_in.ep, rx_in.index}] <= rx_in.data; // [RQ7]
  end

  ////////////////////////////////////////////////////////////////////////
  // Processor read port, data one cycle after the read strobe

  wire [7:0] rd_sel = (io_addr_in == `DATA_EP1_MODE_ADDR) ? mode_q[0] :
    (io_addr_in == `DATA_EP2_MODE_ADDR) ? mode_q[1] :
    io_in_buf ? buf_mem[io_off[4:0]] : `READ_UNMAPPED;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) io_rdata_out <= 8'h00;
    else if (io_rd_in) io_rdata_out <= rd_sel;
  end

  ////////////////////////////////////////////////////////////////////////
  // Handshake and interrupt outputs

  logic [2:0] irq_d;
  // Interrupt on ACK, on acknowledged IN data, and on NAK if enabled
  generate
    for (gi = 0; gi < 3; gi++) begin : g_irq
      wire [1:0] ep_num = 2'(gi);
      assign irq_d[gi] = (tok_fire && tok_in.ep == ep_num &&
        (decision == R_ACK || (decision == R_NAK && tok_nak_irq))) ||
        (host_ack_in && pend_q && pend_ep_q == ep_num); // [RQ3]
    end
  endgenerate

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      resp_valid_out <= 1'b0;
      resp_out <= R_NONE;
      resp_len_out <= 4'h0;
      ep_irq_out <= 3'h0;
    end else begin
      resp_valid_out <= tok_fire && decision != R_NONE; // [RQ9] [RQ22]
      resp_out <= tok_fire ? decision : R_NONE;
      resp_len_out <= (tok_fire && decision == R_TX) ? tx_len : 4'h0;
      ep_irq_out <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // IN byte reader feeding the two-entry buffer

  tx_state_t state_q;
  logic [3:0] idx_q;
  logic [3:0] len_q;
  logic [1:0] tx_ep_q;
  logic push_ready;
  wire push_valid = (state_q == TX_SEND);
  wire push_last = (idx_q + 4'h1 == len_q);
  wire tx_start = tok_fire && decision == R_TX && tx_len != 4'h0;
  wire tx_beat_t push_beat = '{last: push_last,
    data: buf_mem[{tx_ep_q, idx_q[2:0]}]};

  // The reader stalls whenever the buffer is full, so no byte is lost
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= TX_IDLE;
      idx_q <= 4'h0;
      len_q <= 4'h0;
      tx_ep_q <= 2'h0;
    end else begin
      case (state_q)
        TX_IDLE: begin
          if (tx_start) begin
            state_q <= TX_SEND;
            idx_q <= 4'h0;
            len_q <= tx_len; // [RQ24]
            tx_ep_q <= tok_in.ep;
          end
        end
        TX_SEND: begin
          if (push_ready) begin
            idx_q <= idx_q + 4'h1;
            if (push_last) state_q <= TX_IDLE; // [RQ24]
          end
        end
        default: state_q <= TX_IDLE;
      endcase
    end
  end

  tx_skid_buffer u_tx_buf (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .in_valid_in(push_valid),
    .in_beat_in(push_beat),
    .in_ready_out(push_ready),
    .out_valid_out(tx_valid_out),
    .out_beat_out(tx_beat_out),
    .out_ready_in(tx_ready_in)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  logic [3:0] sent_q;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) sent_q <= 4'h0;
    else if (tx_start) sent_q <= 4'h0;
    else if (push_valid && push_ready) sent_q <= sent_q + 4'h1;
  end

  sequence s_out_to_data(logic stl);
    tok_fire && !tok_ctrl && tok_in.kind == TK_OUT && pkt_ok &&
    tok_mode == `MODE_ACK_OUT && tok_reg.stall == stl;
  endsequence

  a_stall_out_ack: assert property ( // [RQ1] [RQ18]
    s_out_to_data(1'b1) |=> resp_valid_out && resp_out == R_STALL)
    else $error("stalled ACK-OUT endpoint did not STALL");

  a_out_auto_nak: assert property ( // [RQ17] [RQ4]
    s_out_to_data(1'b0) |=> resp_out == R_ACK &&
    mode_q[$past(tok_sel)].mode == `MODE_NAK_OUT &&
    mode_q[$past(tok_sel)].acked)
    else $error("ACKed OUT did not move mode to NAK OUT");

  a_in_auto_nak: assert property ( // [RQ20]
    (in_ack[0] && !in_ack[1]) |=> mode_q[0].mode == `MODE_NAK_IN &&
    ep_irq_out[1])
    else $error("acknowledged IN did not move mode to NAK IN");

  a_nak_irq_gate: assert property ( // [RQ3]
    tok_fire && !tok_ctrl && decision == R_NAK && !tok_reg.nak_ie |=>
    resp_out == R_NAK && !ep_irq_out[$past(tok_in.ep)])
    else $error("NAK raised interrupt while disabled");

  a_update_block: assert property ( // [RQ5]
    eng_wr[0] && !eng_wr[1] && io_wr_in &&
    io_addr_in == `DATA_EP2_MODE_ADDR |=>
    $stable(mode_q[1]))
    else $error("firmware write landed during engine update");

  a_disabled_quiet: assert property ( // [RQ9] [RQ22]
    tok_fire && (tok_mode == `MODE_DISABLED ||
    tok_mode == 4'h5 || tok_mode == 4'ha) |=> !resp_valid_out)
    else $error("disabled endpoint answered a token");

  a_status_check: assert property ( // [RQ23] [RQ11]
    tok_fire && tok_ctrl && tok_in.kind == TK_OUT && pkt_ok &&
    tok_mode == `MODE_STATUS_OUT |=>
    resp_out == ($past(tok_in.count) == `RX_COUNT_EMPTY &&
    $past(tok_in.toggle) ? R_ACK : R_STALL))
    else $error("status check answered wrongly");

  a_tx_count_sent: assert property ( // [RQ24]
    tx_start && state_q == TX_IDLE |=> ##[1:200]
    (state_q == TX_IDLE && sent_q == $past(len_q)))
    else $error("IN data did not send the loaded count");
endmodule // usb_endpoint_mode_control

// >>> tb/usb_host_model.sv
// Host side model: token source and IN data sink for the endpoint block.
// Assumes one clock; with slow_in high the sink takes every other cycle.
`timescale 1ns/1ns
module usb_host_model (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic req_in,
  input wire usb_ep_pkg::token_t cmd_in,
  input wire logic slow_in,
  input wire logic tx_valid_in,
  input wire usb_ep_pkg::tx_beat_t tx_beat_in,
  output logic tok_valid_out,
  output usb_ep_pkg::token_t tok_out,
  output logic tx_ready_out,
  output logic [3:0] got_n_out,
  output logic [7:0][7:0] got_out,
  output logic got_last_out
);
  import usb_ep_pkg::*;
  token_t last_q;
  logic phase_q;
  // Idle token lines show the inverse of the last token, never a copy
  assign tok_valid_out = req_in;
  assign tok_out = req_in ? cmd_in : ~last_q;
  assign tx_ready_out = !slow_in || phase_q;
  ////////////////////////////////////////////////////////////////////////
  // Sink: beats kept in arrival order; a new token starts a fresh count
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      last_q <= '0;
      phase_q <= 1'b0;
      got_n_out <= 4'h0;
      got_out <= '0;
      got_last_out <= 1'b0;
    end else begin
      phase_q <= !phase_q;
      if (req_in) begin
        last_q <= cmd_in;
        got_n_out <= 4'h0;
        got_last_out <= 1'b0;
      end else if (tx_valid_in && tx_ready_out) begin
        got_out[got_n_out[2:0]] <= tx_beat_in.data;
        got_n_out <= got_n_out + 4'h1;
        got_last_out <= tx_beat_in.last;
      end
    end
  end
endmodule // usb_host_model

// >>> tb/usb_endpoint_mode_control_bench.sv
// Self-checking bench for the endpoint mode block with a host model.
// Assumes firmware-side accesses one at a time and idle gaps between tokens.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  err_total++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module usb_endpoint_mode_control_bench;
  import usb_ep_pkg::*;
  typedef struct {
    logic [1:0] ep; logic [7:0] m; tok_kind_t k; logic [3:0] c;
    logic ok; logic tg; resp_t r; logic [3:0] len; logic [2:0] irq;
    logic [7:0] aft;
  } row_t;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata, d;
  logic io_wr = 1'b0, io_rd = 1'b0, rx_valid = 1'b0, host_ack = 1'b0;
  logic [3:0] ctrl_mode = 4'h0, len, got_n, len_w;
  logic [2:0][3:0] tx_count = {4'h5, 4'h0, 4'h3};
  rx_byte_t rx = '0;
  logic resp_valid, tok_valid, tx_valid, tx_ready, req = 1'b0;
  logic slow = 1'b0, got_last;
  resp_t resp, r;
  logic [2:0] ep_irq, q;
  tx_beat_t tx_beat;
  token_t tok, cmd = '0;
  logic [7:0][7:0] got;
  logic [4:0][3:0] resv = {4'h4, 4'h5, 4'h7, 4'ha, 4'he};
  int err_total = 0, num_checks = 0, cyc = 0;
  // Ordinary cases: mode, token, expected reply, interrupt, mode after
  row_t rows[27] = '{
    '{2'h0,8'h00,TK_SETUP,4'h2,1,0,R_NONE,4'h0,3'h0,8'h00},
    '{2'h0,8'h01,TK_SETUP,4'h2,1,0,R_ACK,4'h0,3'h0,8'h00},
    '{2'h0,8'h01,TK_IN,4'h2,1,0,R_NAK,4'h0,3'h0,8'h00},
    '{2'h0,8'h01,TK_OUT,4'h4,1,0,R_NAK,4'h0,3'h0,8'h00},
    '{2'h0,8'h01,TK_SETUP,4'hb,1,0,R_NONE,4'h0,3'h0,8'h00},
    '{2'h0,8'h01,TK_SETUP,4'h2,0,0,R_NONE,4'h0,3'h0,8'h00},
    '{2'h0,8'h02,TK_IN,4'h2,1,0,R_STALL,4'h0,3'h0,8'h00},
    '{2'h0,8'h02,TK_OUT,4'h2,1,1,R_ACK,4'h0,3'h0,8'h00},
    '{2'h0,8'h03,TK_IN,4'h2,1,0,R_STALL,4'h0,3'h0,8'h00},
    '{2'h0,8'h03,TK_OUT,4'h2,1,1,R_STALL,4'h0,3'h0,8'h00},
    '{2'h0,8'h06,TK_IN,4'h2,1,0,R_TX,4'h0,3'h0,8'h00},
    '{2'h0,8'h06,TK_OUT,4'h2,1,1,R_STALL,4'h0,3'h0,8'h00},
    '{2'h0,8'h0b,TK_OUT,4'h4,1,0,R_ACK,4'h0,3'h0,8'h00},
    '{2'h0,8'h0b,TK_IN,4'h2,1,0,R_TX,4'h0,3'h0,8'h00},
    '{2'h0,8'h0f,TK_IN,4'h2,1,0,R_TX,4'h3,3'h0,8'h00},
    '{2'h0,8'h0f,TK_OUT,4'h2,1,1,R_ACK,4'h0,3'h0,8'h00},
    '{2'h0,8'h0f,TK_OUT,4'h4,1,1,R_STALL,4'h0,3'h0,8'h00},
    '{2'h0,8'h0f,TK_OUT,4'h2,1,0,R_STALL,4'h0,3'h0,8'h00},
    '{2'h1,8'h09,TK_OUT,4'h2,1,0,R_ACK,4'h0,3'h2,8'h18},
    '{2'h1,8'h89,TK_OUT,4'h2,1,0,R_STALL,4'h0,3'h0,8'h89},
    '{2'h1,8'h89,TK_IN,4'h2,1,0,R_NONE,4'h0,3'h0,8'h89},
    '{2'h2,8'h08,TK_OUT,4'h2,1,0,R_NAK,4'h0,3'h0,8'h08},
    '{2'h2,8'h28,TK_OUT,4'h2,1,0,R_NAK,4'h0,3'h4,8'h28},
    '{2'h2,8'h08,TK_SETUP,4'h2,1,0,R_NONE,4'h0,3'h0,8'h08},
    '{2'h1,8'h0c,TK_IN,4'h2,1,0,R_NAK,4'h0,3'h0,8'h0c},
    '{2'h2,8'h8d,TK_IN,4'h2,1,0,R_STALL,4'h0,3'h0,8'h8d},
    '{2'h2,8'h8d,TK_OUT,4'h2,1,0,R_NONE,4'h0,3'h0,8'h8d}
  };
  usb_endpoint_mode_control dut_u (
    .clk_in(clk_in), .reset_in(reset_in), .io_addr_in(io_addr),
    .io_wdata_in(io_wdata), .io_wr_in(io_wr), .io_rd_in(io_rd),
    .io_rdata_out(io_rdata), .ctrl_mode_in(ctrl_mode),
    .tx_count_in(tx_count), .tok_valid_in(tok_valid), .tok_in(tok),
    .rx_valid_in(rx_valid), .rx_in(rx), .host_ack_in(host_ack),
    .resp_valid_out(resp_valid), .resp_out(resp), .resp_len_out(len_w),
    .ep_irq_out(ep_irq), .tx_valid_out(tx_valid), .tx_beat_out(tx_beat),
    .tx_ready_in(tx_ready)
  );
  usb_host_model host_u (
    .clk_in(clk_in), .reset_in(reset_in), .req_in(req), .cmd_in(cmd),
    .slow_in(slow), .tx_valid_in(tx_valid), .tx_beat_in(tx_beat),
    .tok_valid_out(tok_valid), .tok_out(tok), .tx_ready_out(tx_ready),
    .got_n_out(got_n), .got_out(got), .got_last_out(got_last)
  );
  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #10 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Register side bus cycles, one strobe cycle each
  task automatic io_write(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in); #2;
    io_addr = a; io_wdata = v; io_wr = 1'b1;
    @(posedge clk_in); #2;
    io_wr = 1'b0;
  endtask
  task automatic io_read(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_in); #2;
    io_addr = a; io_rd = 1'b1;
    @(posedge clk_in); #2;
    io_rd = 1'b0;
    @(posedge clk_in); #2;
    v = io_rdata;
  endtask
  // Reply stands one cycle, so both candidate cycles are watched
  task automatic send_tok(input tok_kind_t k, input logic [1:0] ep,
      input logic [3:0] c, input logic ok, input logic tg);
    @(posedge clk_in); #2;
    cmd = '{k, ep, c, ok, tg}; req = 1'b1;
    @(posedge clk_in); #2;
    req = 1'b0; r = R_NONE; len = 4'h0; q = 3'h0;
    repeat (2) begin
      if (resp_valid === 1'b1) begin
        r = resp; len = len_w;
      end
      q = q | ep_irq;
      @(posedge clk_in); #2;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_in);
    #2 reset_in = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].ep == 2'h0) ctrl_mode = rows[i].m[3:0];
      else io_write(8'h44 + rows[i].ep, rows[i].m);
      send_tok(rows[i].k, rows[i].ep, rows[i].c, rows[i].ok, rows[i].tg);
      `CHK("resp", rows[i].r, r)
      if (r == R_TX) `CHK("len", rows[i].len, len)
      if (rows[i].ep != 2'h0) begin
        `CHK("irq", rows[i].irq, q)
        io_read(8'h44 + rows[i].ep, d);
        `CHK("mode", rows[i].aft, d)
      end
      repeat (8) @(posedge clk_in);
      #2;
    end
    // Reserved codes on control and data endpoints alike
    foreach (resv[i]) begin
      io_write(8'h45, {4'h0, resv[i]}); // Stall kept clear
      ctrl_mode = resv[i];
      send_tok(TK_IN, 2'h1, 4'h2, 1'b1, 1'b0);
      `CHK("resv in", R_NONE, r)
      send_tok(TK_OUT, 2'h1, 4'h2, 1'b1, 1'b0);
      `CHK("resv out", R_NONE, r)
      send_tok(TK_SETUP, 2'h0, 4'h2, 1'b1, 1'b0);
      `CHK("resv setup", R_NONE, r)
    end
    // Register reset state is seen again after a second reset
    @(posedge clk_in); #2 reset_in = 1'b1;
    @(posedge clk_in); #2 reset_in = 1'b0;
    io_read(8'h45, d);
    `CHK("ep1 reset", 8'h00, d)
    io_read(8'h46, d);
    `CHK("ep2 reset", 8'h00, d)
    io_write(8'h45, 8'h40);
    io_read(8'h45, d);
    `CHK("reserved bit", 8'h40, d)
    io_read(8'h68, d);
    `CHK("unmapped", 8'h00, d)
    // Every buffer byte, including both ends of each buffer
    for (int i = 0; i < 24; i++) io_write(8'h50 + 8'(i), 8'(i * 29 + 90));
    for (int i = 0; i < 24; i++) begin
      io_read(8'h50 + 8'(i), d);
      `CHK("buffer", 8'(i * 29 + 90), d)
    end
    // Engine byte lands in the first data endpoint buffer
    @(posedge clk_in); #2;
    rx = '{2'h1, 3'h3, 8'ha5}; rx_valid = 1'b1;
    @(posedge clk_in); #2;
    rx_valid = 1'b0; rx = ~rx;
    io_read(8'h5b, d);
    `CHK("rx byte", 8'ha5, d)
    // IN data with a stalling sink, then host acknowledge
    slow = 1'b1;
    io_write(8'h46, 8'h0d);
    send_tok(TK_IN, 2'h2, 4'h2, 1'b1, 1'b0);
    `CHK("tx resp", R_TX, r)
    `CHK("tx len", 4'h5, len)
    for (int w = 0; w < 40 && got_n != 4'h5; w++) @(posedge clk_in);
    repeat (4) @(posedge clk_in);
    `CHK("tx count", 4'h5, got_n)
    `CHK("tx last", 1'b1, got_last)
    // Second data endpoint bytes sit at buffer offsets 16 and up
    for (int i = 0; i < 5; i++)
      `CHK("tx data", 8'((i + 16) * 29 + 90), got[i])
    @(posedge clk_in); #2 host_ack = 1'b1;
    @(posedge clk_in); #2 host_ack = 1'b0;
    q = ep_irq;
    @(posedge clk_in); #2 q = q | ep_irq;
    `CHK("ack irq", 3'h4, q)
    io_read(8'h46, d);
    `CHK("after in", 8'h1c, d)
    // Empty IN on the first data endpoint, then host acknowledge
    io_write(8'h45, 8'h0d);
    send_tok(TK_IN, 2'h1, 4'h2, 1'b1, 1'b0);
    `CHK("ep1 in resp", R_TX, r)
    `CHK("ep1 in len", 4'h0, len)
    @(posedge clk_in); #2 host_ack = 1'b1;
    @(posedge clk_in); #2 host_ack = 1'b0;
    q = ep_irq;
    @(posedge clk_in); #2 q = q | ep_irq;
    `CHK("ep1 ack irq", 3'h2, q)
    io_read(8'h45, d);
    `CHK("ep1 after in", 8'h1c, d)
    // Engine update collides with a firmware write to the other register
    io_write(8'h45, 8'h09);
    io_write(8'h46, 8'h08);
    @(posedge clk_in); #2;
    cmd = '{TK_OUT, 2'h1, 4'h2, 1'b1, 1'b0}; req = 1'b1;
    io_addr = 8'h46; io_wdata = 8'h0c; io_wr = 1'b1;
    @(posedge clk_in); #2;
    req = 1'b0; io_wr = 1'b0;
    io_read(8'h46, d);
    `CHK("dropped write", 8'h08, d)
    io_read(8'h45, d);
    `CHK("engine write", 8'h18, d)
    io_write(8'h46, 8'h0c);
    io_read(8'h46, d);
    `CHK("rewrite", 8'h0c, d)
    io_write(8'h45, 8'h18);
    io_read(8'h45, d);
    `CHK("acked clear", 8'h08, d)
    stop_test();
  end
endmodule // usb_endpoint_mode_control_bench
